// [rtl/mpi_pkg.sv]
package mpi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_SHUT = 8'h0c;
  localparam logic [7:0] OFS_TOOL = 8'h10;
  localparam logic [7:0] OFS_VSCALE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_SCALE = 8'h1c;
  localparam logic [7:0] OFS_MEAS = 8'h20;
  // CFG fields
  localparam int CFG_CTL_LSB = 0;
  localparam int CFG_DRV_LSB = 4;
  localparam int CFG_FB_LSB = 8;
  localparam int CFG_SHM_LSB = 12;
  localparam int CFG_NPOS_LSB = 16;
  localparam int CFG_CUR_LSB = 24;
  // CTRL bits (write one to act)
  localparam int CTRL_GO = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_LAYER_DONE = 2;
  localparam int CTRL_CLR_ERR = 3;
  localparam int CTRL_SNS_FAIL = 4;
  localparam int CTRL_LOAD_POS = 5;
  localparam int CTRL_TGT_LSB = 8;
  // Positions and widths
  localparam int NPOS_MAX = 16;
  localparam int POS_W = 4;
  localparam int BCD_W = 4;
  // Reset values
  localparam logic [3:0] NPOS_RST = 4'h1;
  localparam logic [15:0] TOOL_UNITY = 16'h0064; // 100 percent
  localparam logic [15:0] VSCALE_RST = 16'h0064; // +10.0 V in 0.1 V steps
  // Timing: delays are in milliseconds
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int GAP_CYC = PULSE_CYC;
  typedef enum logic [2:0] {CT_MANUAL, CT_DIRECT, CT_BCD, CT_INDIV} mpi_ctl_e;
  typedef enum logic [2:0] {DR_UP, DR_DOWN, DR_FAST, DR_INLINE, DR_SSTEP, DR_DSTEP} mpi_drv_e;
  typedef enum logic [2:0] {FB_NONE, FB_INDIV, FB_BCD, FB_HOME, FB_INPOS} mpi_fb_e;
  typedef enum logic [1:0] {SH_NONE, SH_DUAL, SH_YES} mpi_shm_e;
endpackage : mpi_pkg

// [rtl/mpi_tmr_if.sv]
`timescale 1ns/10ps
interface mpi_tmr_if;
  logic start;
  logic [31:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : mpi_tmr_if

// [rtl/mpi_timer.sv]
`timescale 1ns/10ps
module mpi_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  mpi_tmr_if.tmr t
);
  logic [31:0] cnt_r;
  logic run_r;

  // Down counter; done pulses once when the count runs out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      t.done <= 1'b0;
    end else begin
      t.done <= 1'b0;
      if (t.start) begin
        cnt_r <= (t.load == 32'h0) ? 32'h1 : t.load;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 32'h1) begin
          run_r <= 1'b0;
          t.done <= 1'b1;
        end
        cnt_r <= cnt_r - 32'h1;
      end
    end
  end
endmodule : mpi_timer

// [rtl/mpi_indexer.sv]
`timescale 1ns/10ps
// Functional notes
// - Manual control: halt after layer, request position, resume on continue
// - Direct control drives one or two direction outputs
// - Up type uses up output only; down type uses down output only
// - Fast type picks the shorter direction
// - Inline type never wraps; lower target means travel down
// - Step types pulse the valve output
// - BCD control presents target code on relay lines
// - Individual control asserts only the target's line
// - No feedback: position tracked internally from configured value
// - Individual feedback: one input per position, true when in place
// - BCD feedback decodes position minus one
// - Single home input true only at position one
// - In-position input true whenever any position aligned
// - No feedback: wait indexer delay then assume arrival
// - Feedback: wait indexer delay, else timeout error
// - Configurable position count per input
// - In-position or no feedback: position from operator value
// - Shutter modes none, dual, yes
// - Shutter yes: wait shutter delay before using sensor
// - Rate and thickness scaled by tooling percent
// - Source voltage scale sets full-scale output; here VSCALE is only stored and read back
module mpi_indexer (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Actuator outputs
  output logic DRIVE_UP,
  output logic DRIVE_DOWN,
  output logic VALVE_PULSE,
  output logic [3:0] SEL_BCD,
  output logic [15:0] SEL_LINE,
  output logic SHUTTER_OPEN,
  output logic SENSOR_READY,
  output logic HALTED,
  output logic POS_TIMEOUT,
  // Position feedback pins
  input wire logic [15:0] FB_IN
);
  // Configuration registers
  logic [31:0] cfg_r;
  logic [15:0] delay_r, shut_r, tool_r, vscale_r;
  logic [31:0] meas_r, scaled_r;
  logic [15:0] fb_s1_r, fb_s2_r;
  logic [3:0] pos_r, tgt_r;
  logic err_r, halt_r, busy_r, pend_r, shut_wait_r, ready_r, left_r;
  logic rd_ack_r;

  wire [2:0] ctl = cfg_r[mpi_pkg::CFG_CTL_LSB +: 3];
  wire [2:0] drv = cfg_r[mpi_pkg::CFG_DRV_LSB +: 3];
  wire [2:0] fb = cfg_r[mpi_pkg::CFG_FB_LSB +: 3];
  wire [1:0] shm = cfg_r[mpi_pkg::CFG_SHM_LSB +: 2];
  wire [3:0] npos_m1 = cfg_r[mpi_pkg::CFG_NPOS_LSB +: 4]; // count minus one
  wire [3:0] cur_cfg = cfg_r[mpi_pkg::CFG_CUR_LSB +: 4];

  wire wr_ctrl = AVS_WRITE && AVS_ADDRESS == mpi_pkg::OFS_CTRL;
  wire go = wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_GO];
  wire cont = wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_CONT];
  wire layer_done = wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_LAYER_DONE];
  wire clr_err = wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_CLR_ERR];
  wire sns_fail = wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_SNS_FAIL];
  wire [3:0] wr_tgt = AVS_WRITEDATA[mpi_pkg::CTRL_TGT_LSB +: 4];

  // Writes take effect at once; reads answer one cycle later
  assign AVS_WAITREQUEST = AVS_READ && !rd_ack_r;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= AVS_READ && !rd_ack_r;
    end
  end

  // Feedback pins pass two flip-flops first
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      fb_s1_r <= 16'h0;
      fb_s2_r <= 16'h0;
    end else begin
      fb_s1_r <= FB_IN;
      fb_s2_r <= fb_s1_r;
    end
  end

  // In-position is still true as a move starts; only a reading after it dropped counts
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      left_r <= 1'b0;
    end else if (go && !busy_r) begin
      left_r <= 1'b0;
    end else if (busy_r && !fb_s2_r[0]) begin
      left_r <= 1'b1;
    end
  end

  // Decode feedback to an arrival flag and a sensed position
  logic fb_hit;
  logic [3:0] fb_pos;
  always_comb begin
    fb_hit = 1'b0;
    fb_pos = tgt_r; // In-position arrival adopts the target
    unique case (fb)
      mpi_pkg::FB_INDIV: begin
        fb_hit = fb_s2_r[tgt_r];
        fb_pos = tgt_r;
      end
      mpi_pkg::FB_BCD: begin
        fb_pos = fb_s2_r[3:0]; // code is position minus one
        fb_hit = (fb_s2_r[3:0] == tgt_r);
      end
      mpi_pkg::FB_HOME: begin
        fb_hit = fb_s2_r[0] && tgt_r == 4'h0;
        fb_pos = fb_hit ? 4'h0 : pos_r;
      end
      mpi_pkg::FB_INPOS: fb_hit = fb_s2_r[0] && left_r;
      default: fb_hit = 1'b0;
    endcase
  end

  // Move timer and shutter timer
  mpi_tmr_if mv_t ();
  mpi_tmr_if sh_t ();
  mpi_timer u_mv (.clk(CLOCK), .rst_n(RESETN), .t(mv_t));
  mpi_timer u_sh (.clk(CLOCK), .rst_n(RESETN), .t(sh_t));
  assign mv_t.load = delay_r * 32'(mpi_pkg::MS_CYC);
  assign sh_t.load = shut_r * 32'(mpi_pkg::MS_CYC);

  // Direction choice; positions held internally as index from zero
  logic up_dir;
  logic [3:0] fwd, back;
  always_comb begin
    fwd = (tgt_r >= pos_r) ? tgt_r - pos_r : 4'(tgt_r + npos_m1 + 4'h1 - pos_r);
    back = (pos_r >= tgt_r) ? pos_r - tgt_r : 4'(pos_r + npos_m1 + 4'h1 - tgt_r);
    unique case (drv)
      mpi_pkg::DR_DOWN: up_dir = 1'b0;
      mpi_pkg::DR_FAST: up_dir = fwd <= back;
      mpi_pkg::DR_INLINE: up_dir = tgt_r > pos_r;
      default: up_dir = 1'b1;
    endcase
  end

  wire step_type = drv == mpi_pkg::DR_SSTEP || drv == mpi_pkg::DR_DSTEP;
  wire [1:0] pulses_per = (drv == mpi_pkg::DR_DSTEP) ? 2'd2 : 2'd1;
  logic [31:0] pcnt_r;
  logic [4:0] pleft_r;
  logic phigh_r;

  // Move sequencing: start, hold drive, then settle on delay or feedback
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pos_r <= 4'h0;
      tgt_r <= 4'h0;
      busy_r <= 1'b0;
      halt_r <= 1'b0;
      pend_r <= 1'b0;
      err_r <= 1'b0;
      mv_t.start <= 1'b0;
    end else begin
      mv_t.start <= 1'b0;
      if (wr_ctrl && AVS_WRITEDATA[mpi_pkg::CTRL_LOAD_POS]) pos_r <= cur_cfg;
      if (clr_err && !(busy_r && mv_t.done && !fb_hit && fb != mpi_pkg::FB_NONE))
        err_r <= 1'b0;
      if (go && !busy_r) begin
        tgt_r <= (wr_tgt > npos_m1) ? npos_m1 : wr_tgt;
        if (ctl == mpi_pkg::CT_MANUAL) begin
          pend_r <= (wr_tgt != pos_r);
        end else if (wr_tgt != pos_r || fb != mpi_pkg::FB_NONE) begin
          busy_r <= 1'b1;
          mv_t.start <= 1'b1;
        end
      end
      if (layer_done && ctl == mpi_pkg::CT_MANUAL && pend_r) halt_r <= 1'b1;
      if (cont && halt_r) begin
        halt_r <= 1'b0;
        pend_r <= 1'b0;
        pos_r <= tgt_r;
      end
      if (busy_r) begin
        if (fb != mpi_pkg::FB_NONE && fb_hit) begin
          busy_r <= 1'b0; // feedback confirms arrival
          pos_r <= fb_pos;
        end else if (mv_t.done) begin
          busy_r <= 1'b0;
          if (fb == mpi_pkg::FB_NONE) pos_r <= tgt_r;
          else err_r <= 1'b1;
        end
      end
    end
  end

  // Valve pulse train: fixed width high, equal gap
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pcnt_r <= 32'h0;
      pleft_r <= 5'd0;
      phigh_r <= 1'b0;
    end else if (mv_t.start && step_type && ctl == mpi_pkg::CT_DIRECT) begin
      pleft_r <= 5'(fwd) * 5'(pulses_per); // pulses per position advanced
      phigh_r <= fwd != 4'h0;
      pcnt_r <= 32'(mpi_pkg::PULSE_CYC);
    end else if (pleft_r != 5'd0) begin
      if (pcnt_r == 32'h1) begin
        phigh_r <= !phigh_r; // The last pulse ends with nothing left, so no trailing gap
        if (phigh_r) pleft_r <= pleft_r - 5'd1;
        pcnt_r <= phigh_r ? 32'(mpi_pkg::GAP_CYC) : 32'(mpi_pkg::PULSE_CYC);
      end else begin
        pcnt_r <= pcnt_r - 32'h1;
      end
    end
  end

  // Actuator outputs, registered
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      DRIVE_UP <= 1'b0;
      DRIVE_DOWN <= 1'b0;
      VALVE_PULSE <= 1'b0;
      SEL_BCD <= 4'h0;
      SEL_LINE <= 16'h0;
    end else begin
      DRIVE_UP <= busy_r && ctl == mpi_pkg::CT_DIRECT && !step_type && up_dir;
      DRIVE_DOWN <= busy_r && ctl == mpi_pkg::CT_DIRECT && !step_type && !up_dir;
      VALVE_PULSE <= phigh_r;
      SEL_BCD <= (ctl == mpi_pkg::CT_BCD) ? tgt_r : 4'h0;
      SEL_LINE <= (ctl == mpi_pkg::CT_INDIV) ? 16'h1 << tgt_r : 16'h0;
    end
  end

  // Shutter: yes opens in use and waits its delay; dual opens after failure
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      SHUTTER_OPEN <= 1'b0;
      shut_wait_r <= 1'b0;
      ready_r <= 1'b0;
      sh_t.start <= 1'b0;
    end else begin
      sh_t.start <= 1'b0;
      unique case (shm)
        mpi_pkg::SH_YES: begin
          if (!SHUTTER_OPEN && !busy_r) begin
            SHUTTER_OPEN <= 1'b1;
            shut_wait_r <= 1'b1;
            sh_t.start <= 1'b1;
            ready_r <= 1'b0;
          end else if (shut_wait_r && sh_t.done) begin
            shut_wait_r <= 1'b0;
            ready_r <= 1'b1;
          end
        end
        mpi_pkg::SH_DUAL: begin
          if (sns_fail) SHUTTER_OPEN <= 1'b1;
          ready_r <= 1'b1;
        end
        default: begin
          SHUTTER_OPEN <= 1'b0;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Tooling scale: result = measured * tooling / 100
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      scaled_r <= 32'h0;
    end else begin
      scaled_r <= 32'((64'(meas_r) * 64'(tool_r)) / 64'(mpi_pkg::TOOL_UNITY));
    end
  end

  // Register writes
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cfg_r <= {8'h0, 4'h0, mpi_pkg::NPOS_RST - 4'h1, 16'h0};
      delay_r <= 16'h1;
      shut_r <= 16'h1;
      tool_r <= mpi_pkg::TOOL_UNITY;
      vscale_r <= mpi_pkg::VSCALE_RST;
      meas_r <= 32'h0;
    end else if (AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        mpi_pkg::OFS_CFG: cfg_r <= AVS_WRITEDATA;
        mpi_pkg::OFS_DELAY: delay_r <= AVS_WRITEDATA[15:0];
        mpi_pkg::OFS_SHUT: shut_r <= AVS_WRITEDATA[15:0];
        mpi_pkg::OFS_TOOL: tool_r <= AVS_WRITEDATA[15:0];
        mpi_pkg::OFS_VSCALE: vscale_r <= AVS_WRITEDATA[15:0]; // signed 0.1 V
        mpi_pkg::OFS_MEAS: meas_r <= AVS_WRITEDATA;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped reads return zero
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0;
    end else if (AVS_READ && !rd_ack_r) begin
      unique case (AVS_ADDRESS)
        mpi_pkg::OFS_CFG: AVS_READDATA <= cfg_r;
        mpi_pkg::OFS_DELAY: AVS_READDATA <= {16'h0, delay_r};
        mpi_pkg::OFS_SHUT: AVS_READDATA <= {16'h0, shut_r};
        mpi_pkg::OFS_TOOL: AVS_READDATA <= {16'h0, tool_r};
        mpi_pkg::OFS_VSCALE: AVS_READDATA <= {16'h0, vscale_r};
        mpi_pkg::OFS_STATUS:
          AVS_READDATA <= {16'h0, tgt_r, pos_r, 3'h0, ready_r, pend_r, halt_r, err_r, busy_r};
        mpi_pkg::OFS_SCALE: AVS_READDATA <= scaled_r;
        mpi_pkg::OFS_MEAS: AVS_READDATA <= meas_r;
        default: AVS_READDATA <= 32'h0;
      endcase
    end
  end

  assign SENSOR_READY = ready_r;
  assign HALTED = halt_r;
  assign POS_TIMEOUT = err_r;

  // Checks
  property p_timeout;
    @(posedge CLOCK) disable iff (!RESETN)
      busy_r && mv_t.done && fb != mpi_pkg::FB_NONE && !fb_hit |=> err_r;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");
  property p_nofb;
    @(posedge CLOCK) disable iff (!RESETN)
      busy_r && mv_t.done && fb == mpi_pkg::FB_NONE |=> pos_r == $past(tgt_r) && !busy_r;
  endproperty
  a_nofb: assert property (p_nofb) else $error("position not assumed");
  property p_dirs;
    @(posedge CLOCK) disable iff (!RESETN) !(DRIVE_UP && DRIVE_DOWN);
  endproperty
  a_dirs: assert property (p_dirs) else $error("both drives on");
  property p_line;
    @(posedge CLOCK) disable iff (!RESETN) $countones(SEL_LINE) <= 1;
  endproperty
  a_line: assert property (p_line) else $error("several select lines");
  property p_bcd;
    @(posedge CLOCK) disable iff (!RESETN) ctl == mpi_pkg::CT_BCD |=> SEL_BCD == $past(tgt_r);
  endproperty
  a_bcd: assert property (p_bcd) else $error("bcd select wrong");
  property p_inline;
    @(posedge CLOCK) disable iff (!RESETN)
      busy_r && ctl == mpi_pkg::CT_DIRECT && drv == mpi_pkg::DR_INLINE && tgt_r < pos_r
      |=> !DRIVE_UP;
  endproperty
  a_inline: assert property (p_inline) else $error("inline wrapped up");
  property p_halt;
    @(posedge CLOCK) disable iff (!RESETN) halt_r && !cont |=> halt_r;
  endproperty
  a_halt: assert property (p_halt) else $error("halt released early");
  property p_noshut;
    @(posedge CLOCK) disable iff (!RESETN) shm == mpi_pkg::SH_NONE |=> !SHUTTER_OPEN;
  endproperty
  a_noshut: assert property (p_noshut) else $error("shutter opened in none");
  c_move: cover property (@(posedge CLOCK) disable iff (!RESETN) busy_r ##1 !busy_r);
  c_err: cover property (@(posedge CLOCK) disable iff (!RESETN) $rose(err_r));
  c_valve: cover property (@(posedge CLOCK) disable iff (!RESETN) $rose(VALVE_PULSE));
endmodule : mpi_indexer

// [sim/mpi_head_model.sv]
`timescale 1ns/10ps
// Behavioural rotary head: steps on drive levels or valve pulses, answers on feedback pins
module mpi_head_model (
  // Clock
  input wire logic clk,
  // Actuator lines from the indexer
  input wire logic up,
  input wire logic dn,
  input wire logic valve,
  input wire logic [3:0] sel_bcd,
  input wire logic [15:0] sel_line,
  // Set-up from the bench: 0 direct, 1 coded select, 2 line select
  input wire logic [1:0] ctl,
  input wire logic [2:0] fbm,
  input wire logic [4:0] npos,
  input wire logic [1:0] spp,
  input wire logic ld,
  input wire logic [3:0] ld_pos,
  input wire logic stuck,
  // Feedback pins
  output logic [15:0] fb
);
  logic [3:0] pos_r;
  logic [3:0] cnt_r;
  logic [1:0] pls_r;
  logic valve_d;
  logic [3:0] want;
  logic [3:0] inc;
  logic [3:0] dec;
  logic settled;
  // Position asked for by the select lines; direct mode keeps the present one
  always_comb begin
    want = pos_r;
    if (ctl == 2'h1) want = sel_bcd;
    if (ctl == 2'h2) for (int i = 0; i < 16; i++) if (sel_line[i]) want = i[3:0];
  end
  // Neighbours wrap at the position count, as a rotary head does
  assign inc = ({1'h0, pos_r} == npos - 5'h1) ? 4'h0 : pos_r + 4'h1;
  assign dec = (pos_r == 4'h0) ? npos[3:0] - 4'h1 : pos_r - 4'h1;
  // Nothing reads in place while a select move is pending, in the last 4 cycles of each drive step, or when the head is jammed
  assign settled = !stuck && want == pos_r && cnt_r < 4'hc;
  // Motion: a level drive steps every 16 cycles, a valve advance needs spp pulses
  always_ff @(posedge clk) begin
    valve_d <= valve;
    if (ld) begin
      pos_r <= ld_pos;
      cnt_r <= 4'h0;
      pls_r <= 2'h0;
    end else if (ctl == 2'h0 && (up || dn)) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'hf) pos_r <= up ? inc : dec;
    end else if (ctl == 2'h0 && valve && !valve_d) begin
      pls_r <= (pls_r + 2'h1 == spp) ? 2'h0 : pls_r + 2'h1;
      if (pls_r + 2'h1 == spp) pos_r <= inc;
    end else if (ctl != 2'h0 && want != pos_r) begin
      cnt_r <= (cnt_r == 4'h7) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h7) pos_r <= want;
    end
  end
  // Feedback encodings; open lines read false
  always_comb begin
    fb = 16'h0;
    if (settled) begin
      case (fbm)
        3'h1: fb[pos_r] = 1'b1;
        3'h2: fb[3:0] = pos_r;
        3'h3: fb[0] = (pos_r == 4'h0);
        3'h4: fb[0] = 1'b1;
        default: fb = 16'h0;
      endcase
    end
  end
endmodule : mpi_head_model

// [sim/test_mpi_indexer.sv]
`timescale 1ns/10ps
module test_mpi_indexer;
  typedef struct packed {
    logic [2:0] ctl;
    logic [2:0] drv;
    logic [2:0] fb;
    logic [3:0] n1;
    logic [3:0] cur;
    logic [3:0] tgt;
    logic [31:0] dly;
    logic [1:0] spp;
    logic eu;
    logic ed;
  } mpi_row_s;
  logic CLOCK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [7:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, d;
  logic DRIVE_UP, DRIVE_DOWN, VALVE_PULSE, SHUTTER_OPEN, SENSOR_READY, HALTED, POS_TIMEOUT;
  logic [3:0] SEL_BCD, mpos;
  logic [15:0] SEL_LINE, FB_IN;
  logic [1:0] mctl, mspp, np;
  logic [2:0] mfbm;
  logic [4:0] mn;
  logic mld, mstuck, su, sd, vp_d;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  mpi_row_s r;
  // Fields: control, drive, feedback, positions-1, start, target, delay, pulses, up, down
  mpi_row_s rows [12] = '{
    '{3'h1, 3'h0, 3'h1, 4'h5, 4'h0, 4'h2, 32'h1, 2'h0, 1'h1, 1'h0},
    '{3'h1, 3'h1, 3'h1, 4'h5, 4'h2, 4'h0, 32'h1, 2'h0, 1'h0, 1'h1},
    '{3'h1, 3'h2, 3'h1, 4'h5, 4'h0, 4'h5, 32'h1, 2'h0, 1'h0, 1'h1},
    '{3'h1, 3'h2, 3'h1, 4'h5, 4'h5, 4'h1, 32'h1, 2'h0, 1'h1, 1'h0},
    '{3'h1, 3'h3, 3'h1, 4'h5, 4'h5, 4'h0, 32'h1, 2'h0, 1'h0, 1'h1},
    '{3'h1, 3'h3, 3'h1, 4'h5, 4'h1, 4'h4, 32'h1, 2'h0, 1'h1, 1'h0},
    '{3'h1, 3'h4, 3'h1, 4'hb, 4'h0, 4'h1, 32'h1, 2'h1, 1'h0, 1'h0},
    '{3'h1, 3'h5, 3'h1, 4'h5, 4'h0, 4'h1, 32'h1, 2'h2, 1'h0, 1'h0},
    '{3'h2, 3'h0, 3'h2, 4'h7, 4'h0, 4'h7, 32'h1, 2'h0, 1'h0, 1'h0},
    '{3'h3, 3'h0, 3'h3, 4'h5, 4'h3, 4'h0, 32'h1, 2'h0, 1'h0, 1'h0},
    '{3'h3, 3'h0, 3'h4, 4'hf, 4'h0, 4'h9, 32'h1, 2'h0, 1'h0, 1'h0},
    '{3'h2, 3'h0, 3'h0, 4'h7, 4'h2, 4'h4, 32'h0, 2'h0, 1'h0, 1'h0}
  };
  mpi_indexer mpi_indexer_i (.CLOCK(CLOCK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DRIVE_UP(DRIVE_UP),
    .DRIVE_DOWN(DRIVE_DOWN), .VALVE_PULSE(VALVE_PULSE), .SEL_BCD(SEL_BCD),
    .SEL_LINE(SEL_LINE), .SHUTTER_OPEN(SHUTTER_OPEN), .SENSOR_READY(SENSOR_READY),
    .HALTED(HALTED), .POS_TIMEOUT(POS_TIMEOUT), .FB_IN(FB_IN));
  mpi_head_model mpi_head_model_i (.clk(CLOCK), .up(DRIVE_UP), .dn(DRIVE_DOWN),
    .valve(VALVE_PULSE), .sel_bcd(SEL_BCD), .sel_line(SEL_LINE), .ctl(mctl), .fbm(mfbm),
    .npos(mn), .spp(mspp), .ld(mld), .ld_pos(mpos), .stuck(mstuck), .fb(FB_IN));
  // Free-running 100 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // Records which drive lines rose and how many valve pulses one move used
  always @(posedge CLOCK) begin
    vp_d <= VALVE_PULSE;
    su <= !mld && (su || DRIVE_UP);
    sd <= !mld && (sd || DRIVE_DOWN);
    np <= mld ? 2'h0 : np + {1'h0, VALVE_PULSE && !vp_d};
  end
  // Hang guard: all moves together need well under this many cycles
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      results();
    end
  end
  function automatic logic [31:0] cfg(input logic [2:0] c, input logic [2:0] dv,
    input logic [2:0] f, input logic [1:0] sh, input logic [3:0] n1, input logic [3:0] cu);
    return {4'h0, cu, 4'h0, n1, 2'h0, sh, 1'h0, f, 1'h0, dv, 1'h0, c};
  endfunction : cfg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bus write: held until the edge that samples waitrequest low
  task automatic avw(input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
  endtask : avw
  // Bus read: data taken at the same edge that sees waitrequest low
  task automatic avr(input logic [7:0] a, output logic [31:0] rd);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask : avr
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    RESETN = 1'b0;
    AVS_ADDRESS = 8'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    {mctl, mfbm, mn, mspp, mld, mpos, mstuck} = 18'h0;
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    chk({DRIVE_UP, DRIVE_DOWN, VALVE_PULSE, HALTED, POS_TIMEOUT, SEL_BCD, SEL_LINE}, 32'h0);
    avr(mpi_pkg::OFS_DELAY, d);
    chk(d, 32'h1);
    avr(mpi_pkg::OFS_TOOL, d);
    chk(d[15:0], 16'h64);
    avr(mpi_pkg::OFS_VSCALE, d);
    chk(d[15:0], 16'h64);
    avr(8'h40, d);
    chk(d, 32'h0);
    // Table of moves, one per drive, feedback kind and control kind other than manual
    for (int k = 0; k < 12; k++) begin
      r = rows[k];
      mctl <= (r.ctl == 3'h2) ? 2'h1 : (r.ctl == 3'h3) ? 2'h2 : 2'h0;
      mfbm <= r.fb;
      mn <= {1'h0, r.n1} + 5'h1;
      mspp <= r.spp;
      avw(mpi_pkg::OFS_DELAY, r.dly);
      avw(mpi_pkg::OFS_CFG, cfg(r.ctl, r.drv, r.fb, 2'h0, r.n1, r.cur));
      avw(mpi_pkg::OFS_CTRL, 32'h28);
      mpos <= r.cur;
      mld <= 1'b1;
      @(posedge CLOCK);
      mld <= 1'b0;
      avw(mpi_pkg::OFS_CTRL, {20'h0, r.tgt, 8'h01});
      do avr(mpi_pkg::OFS_STATUS, d); while (d[0] !== 1'b0);
      chk({d[11:8], d[1]}, {r.tgt, 1'b0});
      chk({su, sd, np}, {r.eu, r.ed, r.spp});
      chk(SEL_BCD, (r.ctl == 3'h2) ? r.tgt : 4'h0);
      chk(SEL_LINE, (r.ctl == 3'h3) ? 16'h1 << r.tgt : 16'h0);
      // A valve pulse outlives the move; a pulse still high would hide the next rise
      while (VALVE_PULSE !== 1'b0) @(posedge CLOCK);
    end
    // Jammed head: feedback never comes, so the wait must end in an error
    mctl <= 2'h0;
    mfbm <= 3'h1;
    mstuck <= 1'b1;
    avw(mpi_pkg::OFS_DELAY, 32'h0);
    avw(mpi_pkg::OFS_CFG, cfg(3'h1, 3'h0, 3'h1, 2'h0, 4'h5, 4'h0));
    avw(mpi_pkg::OFS_CTRL, 32'h301);
    do avr(mpi_pkg::OFS_STATUS, d); while (d[0] !== 1'b0);
    chk({POS_TIMEOUT, d[1]}, 2'h3);
    avw(mpi_pkg::OFS_CTRL, 32'h8);
    @(posedge CLOCK);
    chk(POS_TIMEOUT, 1'b0);
    mstuck <= 1'b0;
    // Manual control: pending, halt at layer end, resume on continue
    avw(mpi_pkg::OFS_CFG, cfg(3'h0, 3'h0, 3'h0, 2'h0, 4'h5, 4'h1));
    avw(mpi_pkg::OFS_CTRL, 32'h28);
    avw(mpi_pkg::OFS_CTRL, 32'h301);
    avr(mpi_pkg::OFS_STATUS, d);
    chk({HALTED, d[3]}, 2'h1);
    avw(mpi_pkg::OFS_CTRL, 32'h4);
    @(posedge CLOCK);
    chk(HALTED, 1'b1);
    avw(mpi_pkg::OFS_CTRL, 32'h2);
    avr(mpi_pkg::OFS_STATUS, d);
    chk({HALTED, d[11:8]}, 5'h03);
    // Shutter modes: dual opens only on sensor failure, none never, yes with delay
    avw(mpi_pkg::OFS_CFG, cfg(3'h1, 3'h0, 3'h0, 2'h1, 4'h0, 4'h0));
    @(posedge CLOCK);
    chk(SHUTTER_OPEN, 1'b0);
    avw(mpi_pkg::OFS_CTRL, 32'h10);
    @(posedge CLOCK);
    chk(SHUTTER_OPEN, 1'b1);
    avw(mpi_pkg::OFS_CFG, cfg(3'h1, 3'h0, 3'h0, 2'h0, 4'h0, 4'h0));
    repeat (2) @(posedge CLOCK);
    chk({SHUTTER_OPEN, SENSOR_READY}, 2'h1);
    avw(mpi_pkg::OFS_SHUT, 32'h0);
    avw(mpi_pkg::OFS_CFG, cfg(3'h1, 3'h0, 3'h0, 2'h2, 4'h0, 4'h0));
    repeat (50) if ({SHUTTER_OPEN, SENSOR_READY} !== 2'h3) @(posedge CLOCK);
    chk({SHUTTER_OPEN, SENSOR_READY}, 2'h3);
    // Tooling scale and voltage scale
    avw(mpi_pkg::OFS_MEAS, 32'h3e8);
    avw(mpi_pkg::OFS_TOOL, 32'h96);
    avr(mpi_pkg::OFS_SCALE, d);
    chk(d, 32'h5dc);
    avw(mpi_pkg::OFS_TOOL, 32'h64);
    avr(mpi_pkg::OFS_SCALE, d);
    chk(d, 32'h3e8);
    avw(mpi_pkg::OFS_VSCALE, 32'hffce);
    avr(mpi_pkg::OFS_VSCALE, d);
    chk(d[15:0], 16'hffce);
    results();
  end
endmodule : test_mpi_indexer
